// file: rtl/wds_pkg.sv
package wds_pkg;

   // ==========================================================
   // clock and timebase
   // ==========================================================
   localparam int unsigned CLK_HZ         = 20000000;
   localparam int unsigned TICK_US        = 10;     // prescaler tick period, microseconds
   localparam int unsigned TICK_CYC       = (CLK_HZ / 1000000) * TICK_US;
   localparam int unsigned PRE_W          = 8;
   localparam int unsigned CNT_W          = 24;     // tick counter width, covers 60 s at 10 us

   // ==========================================================
   // variants and output styles
   // ==========================================================
   localparam int unsigned VAR_EQUAL      = 0;      // startup delay equals timeout
   localparam int unsigned VAR_FIXED      = 1;      // fixed 60 s startup delay
   localparam int unsigned VAR_SPLIT      = 2;      // split table with first-edge codes
   localparam int unsigned OUT_OPEN_DRAIN = 0;
   localparam int unsigned OUT_PUSH_PULL  = 1;

   // ==========================================================
   // select codes
   // ==========================================================
   localparam logic [2:0] SEL_DISABLE     = 3'h3;
   localparam logic [2:0] SEL_RESET       = 3'h3;

   // ==========================================================
   // times in microseconds (minimum figures)
   // ==========================================================
   localparam int unsigned T_30US   = 30;
   localparam int unsigned T_200US  = 200;
   localparam int unsigned T_SETUP_US = 300;
   localparam int unsigned T_1MS    = 1000;
   localparam int unsigned T_3MS    = 3000;
   localparam int unsigned T_10MS   = 10000;
   localparam int unsigned T_30MS   = 30000;
   localparam int unsigned T_100MS  = 100000;
   localparam int unsigned T_300MS  = 300000;
   localparam int unsigned T_1S     = 1000000;
   localparam int unsigned T_3S     = 3000000;
   localparam int unsigned T_10S    = 10000000;
   localparam int unsigned T_60S    = 60000000;
   localparam int unsigned T_PULSE_OD_US = 100000;
   localparam int unsigned T_PULSE_PP_US = 1000;

   // minimum times round up to whole ticks
   function automatic logic [CNT_W-1:0] us_to_ticks(input int unsigned us);
      int unsigned t;
      t = (us + TICK_US - 1) / TICK_US;
      if (t < 1) begin
         t = 1;
      end
      return t[CNT_W-1:0];
   endfunction

   localparam logic [CNT_W-1:0] SETUP_TICKS = us_to_ticks(T_SETUP_US);

   typedef enum logic [2:0] {
      WDS_SETUP,
      WDS_STARTUP,
      WDS_FIRST_EDGE,
      WDS_RUN,
      WDS_FAULT,
      WDS_DISABLED
   } wds_state_e;

endpackage

// file: rtl/wds_tick_gen.sv
`timescale 1ns/10ps
// ==========================================================
// free-running prescaler: one-cycle tick every TICK_CYC clocks
// ==========================================================
module wds_tick_gen (
   // clock and reset
   input  wire logic core_clk_in,
   input  wire logic sys_rst_in,
   // tick
   output logic      tick_out
);

   logic [wds_pkg::PRE_W-1:0] pre_q;
   logic [wds_pkg::PRE_W-1:0] pre_d;
   logic                      tick_q;
   logic                      tick_d;

   localparam logic [wds_pkg::PRE_W-1:0] PRE_LAST = wds_pkg::PRE_W'(wds_pkg::TICK_CYC - 1);

   always_comb begin
      pre_d  = pre_q + 8'h01;
      tick_d = 1'b0;
      if (pre_q == PRE_LAST) begin
         pre_d  = '0;
         tick_d = 1'b1;
      end
   end

   // registered tick
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         pre_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         pre_q  <= pre_d;
         tick_q <= tick_d;
      end
   end

   assign tick_out = tick_q;

endmodule

// file: rtl/wds_watchdog.sv
`timescale 1ns/10ps
module wds_watchdog #(
   parameter int unsigned VARIANT   = wds_pkg::VAR_EQUAL,
   parameter int unsigned OUT_STYLE = wds_pkg::OUT_OPEN_DRAIN
) (
   // clock and reset
   input  wire logic core_clk_in,
   input  wire logic sys_rst_in,
   // host side pins
   input  wire logic kick_in,
   input  wire logic timing_sel_b0_in,
   input  wire logic timing_sel_b1_in,
   input  wire logic timing_sel_b2_in,
   // fault pin: level, its driver enable (low = driving), and status
   output logic      fault_pulse_n_out,
   output logic      fault_pulse_n_oe_n_out,
   output logic      startup_delay_out
);

   // ==========================================================
   // input synchronisers
   // ==========================================================
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic [3:0] sync1_d;
   logic [3:0] sync2_d;
   logic       kick_prev_q;
   logic       kick_prev_d;
   logic [2:0] sel_prev_q;
   logic [2:0] sel_prev_d;
   logic       tick;

   always_comb begin
      sync1_d     = {timing_sel_b2_in, timing_sel_b1_in, timing_sel_b0_in, kick_in};
      sync2_d     = sync1_q;
      kick_prev_d = sync2_q[0];
      sel_prev_d  = sync2_q[3:1];
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         sync1_q     <= 4'h0;
         sync2_q     <= 4'h0;
         kick_prev_q <= 1'b0;
         sel_prev_q  <= 3'h0;
      end else begin
         sync1_q     <= sync1_d;
         sync2_q     <= sync2_d;
         kick_prev_q <= kick_prev_d;
         sel_prev_q  <= sel_prev_d;
      end
   end

   wire       kick_edge = sync2_q[0] ^ kick_prev_q;
   wire [2:0] sel_now   = sync2_q[3:1];

   wds_tick_gen u_tick (
      .core_clk_in (core_clk_in),
      .sys_rst_in  (sys_rst_in),
      .tick_out    (tick)
   );

   // ==========================================================
   // timing tables
   // ==========================================================
   // timeout lookup
   function automatic logic [wds_pkg::CNT_W-1:0] timeout_ticks(input logic [2:0] code);
      int unsigned us;
      us = wds_pkg::T_1MS;
      if (VARIANT == wds_pkg::VAR_EQUAL) begin
         case (code)
            3'h0:    us = wds_pkg::T_1MS;
            3'h1:    us = wds_pkg::T_10MS;
            3'h2:    us = wds_pkg::T_30MS;
            3'h4:    us = wds_pkg::T_100MS;
            3'h5:    us = wds_pkg::T_1S;
            3'h6:    us = wds_pkg::T_10S;
            default: us = wds_pkg::T_60S;
         endcase
      end else if (VARIANT == wds_pkg::VAR_FIXED) begin
         case (code)
            3'h0:    us = wds_pkg::T_1MS;
            3'h1:    us = wds_pkg::T_3MS;
            3'h2:    us = wds_pkg::T_10MS;
            3'h4:    us = wds_pkg::T_100MS;
            3'h5:    us = wds_pkg::T_300MS;
            3'h6:    us = wds_pkg::T_3S;
            default: us = wds_pkg::T_60S;
         endcase
      end else begin
         case (code)
            3'h0:    us = wds_pkg::T_3MS;
            3'h1:    us = wds_pkg::T_3S;
            3'h2:    us = wds_pkg::T_1S;
            3'h4:    us = wds_pkg::T_30US;
            3'h5:    us = wds_pkg::T_1S;
            default: us = wds_pkg::T_10S;
         endcase
      end
      return wds_pkg::us_to_ticks(us);
   endfunction

   // startup lookup; equal variant reuses timeout
   function automatic logic [wds_pkg::CNT_W-1:0] startup_ticks(input logic [2:0] code);
      int unsigned us;
      us = wds_pkg::T_60S;
      if (VARIANT == wds_pkg::VAR_SPLIT) begin
         case (code)
            3'h0:    us = wds_pkg::T_3MS;
            3'h1:    us = wds_pkg::T_3S;
            3'h4:    us = wds_pkg::T_200US;
            default: us = wds_pkg::T_60S;
         endcase
      end
      if (VARIANT == wds_pkg::VAR_EQUAL) begin
         return timeout_ticks(code);
      end
      return wds_pkg::us_to_ticks(us);
   endfunction

   // first-edge codes exist only in the split variant
   function automatic logic is_first_edge(input logic [2:0] code);
      return (VARIANT == wds_pkg::VAR_SPLIT) && (code == 3'h5 || code == 3'h6);
   endfunction

   localparam logic [wds_pkg::CNT_W-1:0] PULSE_TICKS = (OUT_STYLE == wds_pkg::OUT_OPEN_DRAIN) ?
      wds_pkg::us_to_ticks(wds_pkg::T_PULSE_OD_US) : wds_pkg::us_to_ticks(wds_pkg::T_PULSE_PP_US);

   // ==========================================================
   // supervisor state machine
   // ==========================================================
   wds_pkg::wds_state_e          state_q;
   wds_pkg::wds_state_e          state_d;
   logic [wds_pkg::CNT_W-1:0]    cnt_q;
   logic [wds_pkg::CNT_W-1:0]    cnt_d;
   logic [2:0]                   code_q;
   logic [2:0]                   code_d;
   logic                         fault_n_q;
   logic                         fault_n_d;
   logic                         oe_n_q;
   logic                         oe_n_d;
   logic                         start_q;
   logic                         start_d;

   // count limit per state; state and code are arguments so the hit net follows them
   function automatic logic [wds_pkg::CNT_W-1:0] cnt_limit(input wds_pkg::wds_state_e st,
                                                           input logic [2:0]          code);
      case (st)
         wds_pkg::WDS_SETUP:   return wds_pkg::SETUP_TICKS;
         wds_pkg::WDS_STARTUP: return startup_ticks(code);
         wds_pkg::WDS_FAULT:   return PULSE_TICKS;
         // kicks land between ticks: one spare tick keeps the timeout at or above its minimum
         default:              return timeout_ticks(code) + 24'h000001;
      endcase
   endfunction

   wire sel_change = (sel_now != sel_prev_q);
   wire cnt_hit    = tick && (cnt_q + 24'h000001 >= cnt_limit(state_q, code_q));

   always_comb begin
      state_d = state_q;
      cnt_d   = tick ? cnt_q + 24'h000001 : cnt_q;
      code_d  = code_q;
      case (state_q)
         wds_pkg::WDS_SETUP: begin
            // settle restarts until the held code matches the pins, so code 000 at power-up is taken too
            if (sel_now != code_q) begin
               code_d = sel_now;
               cnt_d  = '0;
            end else if (cnt_hit) begin
               cnt_d = '0;
               if (code_q == wds_pkg::SEL_DISABLE) begin
                  state_d = wds_pkg::WDS_DISABLED;
               end else if (is_first_edge(code_q)) begin
                  state_d = wds_pkg::WDS_FIRST_EDGE;
               end else begin
                  state_d = wds_pkg::WDS_STARTUP;
               end
            end
         end
         wds_pkg::WDS_STARTUP: begin
            if (cnt_hit) begin
               state_d = wds_pkg::WDS_RUN;
               cnt_d   = '0;
            end
         end
         // wait for first kick without limit
         wds_pkg::WDS_FIRST_EDGE: begin
            cnt_d = '0;
            if (kick_edge) begin
               state_d = wds_pkg::WDS_RUN;
            end
         end
         wds_pkg::WDS_RUN: begin
            if (kick_edge) begin
               cnt_d = '0;
            end else if (cnt_hit) begin
               state_d = wds_pkg::WDS_FAULT;
               cnt_d   = '0;
            end
         end
         wds_pkg::WDS_FAULT: begin
            // kicks and select changes wait for pulse end
            if (cnt_hit) begin
               cnt_d   = '0;
               state_d = (sel_now != code_q) ? wds_pkg::WDS_SETUP : wds_pkg::WDS_RUN;
               code_d  = sel_now;
            end
         end
         default: begin
            cnt_d = '0;
         end
      endcase
      // select change restarts settle and startup, except during a pulse
      if (sel_change && state_q != wds_pkg::WDS_FAULT && state_q != wds_pkg::WDS_SETUP) begin
         state_d = wds_pkg::WDS_SETUP;
         code_d  = sel_now;
         cnt_d   = '0;
      end
      // fault output low only in pulse state
      fault_n_d = (state_d != wds_pkg::WDS_FAULT);
      // open drain drives only while low; push-pull drives whenever out of reset
      oe_n_d    = (OUT_STYLE == wds_pkg::OUT_OPEN_DRAIN) ? fault_n_d : 1'b0;
      start_d   = (state_d == wds_pkg::WDS_SETUP) || (state_d == wds_pkg::WDS_STARTUP) ||
                  (state_d == wds_pkg::WDS_FIRST_EDGE);
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         state_q   <= wds_pkg::WDS_SETUP;
         cnt_q     <= '0;
         code_q    <= wds_pkg::SEL_RESET;
         fault_n_q <= 1'b1;
         oe_n_q    <= 1'b1;
         start_q   <= 1'b1;
      end else begin
         state_q   <= state_d;
         cnt_q     <= cnt_d;
         code_q    <= code_d;
         fault_n_q <= fault_n_d;
         oe_n_q    <= oe_n_d;
         start_q   <= start_d;
      end
   end

   assign fault_pulse_n_out      = fault_n_q;
   assign fault_pulse_n_oe_n_out = oe_n_q;
   assign startup_delay_out      = start_q;

endmodule

// file: testbench/wds_host_model.sv
`timescale 1ns/10ps
// ==========
// host kicking the watchdog
module wds_host_model (
   // clock
   input  wire logic        core_clk_in,
   // control from the bench
   input  wire logic        kick_en_in,
   input  wire logic        toggle_in,
   input  wire logic [15:0] gap_cyc_in,
   // kick pin
   output logic             kick_out
);
   logic [15:0] cnt;
   initial begin
      kick_out = 1'b0;
      cnt = 16'h0;
   end
   // toggle inside the timeout, also from startup on
   always @(posedge core_clk_in) begin
      if (toggle_in || (kick_en_in && cnt >= gap_cyc_in)) begin
         kick_out <= ~kick_out;
         cnt <= 16'h0;
      end else begin
         cnt <= cnt + 16'h1;
      end
   end
endmodule

// file: testbench/wds_watchdog_sva.sv
`timescale 1ns/10ps
// ==========
// fault pin checker, sees the watchdog ports only
module wds_watchdog_chk #(
   parameter int unsigned VARIANT   = 0,
   parameter int unsigned OUT_STYLE = 0
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // host pins
   input wire logic kick_in,
   input wire logic timing_sel_b0_in,
   input wire logic timing_sel_b1_in,
   input wire logic timing_sel_b2_in,
   // fault pin and status
   input wire logic fault_pulse_n_out,
   input wire logic fault_pulse_n_oe_n_out,
   input wire logic startup_delay_out
);
   localparam int unsigned TC = wds_pkg::TICK_CYC;
   localparam int unsigned PT = (OUT_STYLE == 1) ? wds_pkg::T_PULSE_PP_US / wds_pkg::TICK_US
                                                 : wds_pkg::T_PULSE_OD_US / wds_pkg::TICK_US;
   logic [2:0]  sel;
   logic        kick_q;
   logic [23:0] low_q, low_d, quiet_q, quiet_d, kq_q, kq_d;

   assign sel = {timing_sel_b2_in, timing_sel_b1_in, timing_sel_b0_in};

   // pulse length, time since anything that clears the timer, kick stillness
   always_comb begin
      low_d   = fault_pulse_n_out ? 24'h0 : low_q + 24'h1;
      quiet_d = (kick_in != kick_q || startup_delay_out || !fault_pulse_n_out) ? 24'h0 : quiet_q + 24'h1;
      kq_d    = (kick_in != kick_q) ? 24'h0 : kq_q + 24'h1;
   end
   // counters restart with reset so a mid-pulse reset leaves no stale length
   always_ff @(posedge core_clk_in) begin
      kick_q <= kick_in;
      if (sys_rst_in) begin
         low_q   <= 24'h0;
         quiet_q <= 24'h0;
         kq_q    <= 24'h0;
      end else begin
         low_q   <= low_d;
         quiet_q <= quiet_d;
         kq_q    <= kq_d;
      end
   end

   default clocking @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);
   sequence s_calm;
      fault_pulse_n_out [*8];
   endsequence

   a_oe_push_pull: assert property (OUT_STYLE == 1 && !$past(sys_rst_in) |-> !fault_pulse_n_oe_n_out)
      else $error("push-pull enable not driving");
   a_oe_open_drain: assert property (OUT_STYLE == 0 && !$past(sys_rst_in)
                                     |-> fault_pulse_n_oe_n_out == fault_pulse_n_out)
      else $error("open-drain enable differs from pulse");
   a_startup_no_fault: assert property (startup_delay_out |-> fault_pulse_n_out)
      else $error("fault low during startup");
   a_pulse_min_len: assert property ($rose(fault_pulse_n_out) |-> low_q >= (PT - 1) * TC)
      else $error("fault pulse too short");
   a_pulse_max_len: assert property (!fault_pulse_n_out |-> low_q <= (PT + 1) * TC)
      else $error("fault pulse too long");
   a_fault_needs_quiet: assert property ($fell(fault_pulse_n_out) |-> quiet_q >= 3 * TC)
      else $error("fault without a full quiet timeout");
   a_disabled_calm: assert property (sel == 3'h3 && $past(sel, 6) == 3'h3 && fault_pulse_n_out
                                     |=> fault_pulse_n_out)
      else $error("fault while disabled");
   a_first_edge_hold: assert property (VARIANT == 2 && (sel == 3'h5 || sel == 3'h6) && $past(sel, 6) == sel
                                       && startup_delay_out && kq_q >= 24'h6 |=> startup_delay_out)
      else $error("first-edge wait ended without a kick");
   a_startup_end_calm: assert property ($fell(startup_delay_out) |-> s_calm)
      else $error("fault right after startup");
   a_restart_calm: assert property ($rose(fault_pulse_n_out) |-> s_calm)
      else $error("fault right after pulse end");
endmodule

// file: testbench/wds_watchdog_tb.sv
`timescale 1ns/10ps
// ==========
// split table, push-pull: short counts keep the run brief
module wds_watchdog_tb;
   localparam int TC = wds_pkg::TICK_CYC;
   logic        clk, rst, kick, kick_en, tog, fault, oe_n, start, seen_low;
   logic        fault_od, oe_od, start_od;
   logic [2:0]  sel;
   logic [15:0] gap;
   int          n_mismatch, checks_done, cyc, n, seed;

   wds_watchdog #(.VARIANT(wds_pkg::VAR_SPLIT), .OUT_STYLE(wds_pkg::OUT_PUSH_PULL)) dut (
      .core_clk_in(clk), .sys_rst_in(rst), .kick_in(kick),
      .timing_sel_b0_in(sel[0]), .timing_sel_b1_in(sel[1]), .timing_sel_b2_in(sel[2]),
      .fault_pulse_n_out(fault), .fault_pulse_n_oe_n_out(oe_n), .startup_delay_out(start));
   // equal table, open drain, same pins: its long times keep it in startup, which is checked, as is its disabled state
   wds_watchdog #(.VARIANT(wds_pkg::VAR_EQUAL), .OUT_STYLE(wds_pkg::OUT_OPEN_DRAIN)) dut_od (
      .core_clk_in(clk), .sys_rst_in(rst), .kick_in(kick),
      .timing_sel_b0_in(sel[0]), .timing_sel_b1_in(sel[1]), .timing_sel_b2_in(sel[2]),
      .fault_pulse_n_out(fault_od), .fault_pulse_n_oe_n_out(oe_od), .startup_delay_out(start_od));
   wds_host_model host (.core_clk_in(clk), .kick_en_in(kick_en), .toggle_in(tog), .gap_cyc_in(gap), .kick_out(kick));

   // ==========
   // clock and runaway guard
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 95000) begin
         n_mismatch++;
         conclude();
      end
   end

   function automatic int tk(input int t);
      return t * TC;
   endfunction
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   // measured cycle count must fall in a window
   task automatic span(input string what, input int lo, input int hi);
      check(what, {31'h0, n >= lo && n <= hi}, 32'h1);
   endtask
   task automatic wait_pin(input bit use_start, input logic lvl, input int maxc);
      n = 0;
      while (((use_start ? start : fault) !== lvl) && n < maxc) begin
         @(negedge clk);
         n++;
      end
   endtask
   // flags any stray pulse; caller clears the flag
   task automatic hold(input int c);
      repeat (c) begin
         @(negedge clk);
         if (fault !== 1'b1) seen_low = 1'b1;
      end
   endtask
   task automatic kick1;
      tog = 1'b1;
      @(negedge clk);
      tog = 1'b0;
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // ==========
   // main sequence
   initial begin
      seed = 32'h6f47;
      rst = 1'b1; sel = 3'h4; kick_en = 1'b0; tog = 1'b0; gap = 16'h64; seen_low = 1'b0;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      check("startup_at_release", start, 1'b1);
      check("fault_at_release", fault, 1'b1);
      kick_en = 1'b1;
      wait_pin(1, 1'b0, tk(60));
      span("startup_len", tk(48), tk(53));
      check("equal_startup_held", start_od, 1'b1);
      check("od_released", oe_od, 1'b1);
      check("od_fault_idle", fault_od, 1'b1);
      $display("test startup done");
      repeat (20) begin
         gap = 16'(100 + $unsigned($random(seed)) % 300);
         hold(300);
      end
      check("fault_while_kicked", seen_low, 1'b0);
      kick_en = 1'b0;
      kick1;
      wait_pin(0, 1'b0, tk(6));
      span("timeout_len", tk(3), tk(4) + 10);
      check("oe_driving", oe_n, 1'b0);
      repeat (3) begin
         repeat (50) @(negedge clk);
         kick1;
      end
      wait_pin(0, 1'b1, tk(102));
      n = n + 153;
      span("pulse_len", tk(99), tk(101) + 10);
      wait_pin(0, 1'b0, tk(6));
      span("restart_len", tk(3), tk(4) + 10);
      check("no_new_startup", start, 1'b0);
      $display("test pulse done");
      repeat (100) @(negedge clk);
      sel = 3'h0;
      wait_pin(0, 1'b1, tk(102));
      n = n + 100;
      span("old_pulse_len", tk(99), tk(101) + 10);
      repeat (4) @(negedge clk);
      check("settle_after_pulse", start, 1'b1);
      $display("test select_change done");
      rst = 1'b1;
      sel = 3'h3;
      repeat (5) @(negedge clk);
      check("fault_in_reset", fault, 1'b1);
      rst = 1'b0;
      seen_low = 1'b0;
      // settle has to run out first, or the disabled state is never reached
      hold(tk(40));
      check("disabled_quiet", seen_low, 1'b0);
      check("disabled_no_startup", start, 1'b0);
      check("equal_disabled", start_od, 1'b0);
      $display("test disable done");
      sel = 3'h5;
      hold(tk(40));
      check("first_edge_wait", start, 1'b1);
      kick1;
      wait_pin(1, 1'b0, 20);
      span("first_edge_exit", 1, 10);
      hold(tk(2));
      check("run_after_edge", seen_low, 1'b0);
      $display("test first_edge done");
      conclude();
   end
endmodule

bind wds_watchdog wds_watchdog_chk #(.VARIANT(VARIANT), .OUT_STYLE(OUT_STYLE)) u_chk (
   .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .kick_in(kick_in),
   .timing_sel_b0_in(timing_sel_b0_in), .timing_sel_b1_in(timing_sel_b1_in), .timing_sel_b2_in(timing_sel_b2_in),
   .fault_pulse_n_out(fault_pulse_n_out), .fault_pulse_n_oe_n_out(fault_pulse_n_oe_n_out),
   .startup_delay_out(startup_delay_out));
